//--- verilog/ufb_uart.sv
// uart core: flags, baud divisors, line control, tx/rx shifters
// assumes axi4-lite master on REF_CLK; RXD synchronous to REF_CLK
//
// Contract
// R1 - tx empty flag bit7, reset one
// R2 - rx full flag bit6, reset zero
// R3 - tx full flag bit5, reset zero
// R4 - rx empty flag bit4, reset one
// R5 - busy holds through last stop bit
// R6 - busy set when tx buffer nonempty
// R7 - integer divisor bits 15:0, reset zero
// R8 - zero integer divisor means divide by one
// R9 - fraction divisor bits 5:0, reset zero
// R10 - new divisor waits for character end
// R11 - software writes line control after divisor
// R12 - divisors latch on line control write
// R13 - line control holds frame parameters
// R14 - fifo enable selects fifo or holding
// R15 - bit clock = clk/(16*(int+frac/64))
// R16 - reserved bits read zero, ignore writes
`timescale 1ns/1ps
module ufb_uart
   import ufb_pkg::*;
#(
   parameter int DEPTH = 16
) (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic RXD,
   output logic TXD,
   output logic IRQ
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("DEPTH must be a power of two >= 2");
   end

   logic [IBRD_W-1:0] ibrd;
   logic [FBRD_W-1:0] fbrd;
   logic [LCTL_W-1:0] lctl;
   ufb_div_t div_pend;
   ufb_div_t div_act;
   logic [INT_W-1:0] int_stat;
   logic [INT_W-1:0] int_mask;
   logic [7:0] tx_mem [DEPTH];
   logic [7:0] rx_mem [DEPTH];
   logic [AW:0] tx_wp, tx_rp, rx_wp, rx_rp;
   logic [AW:0] tx_cnt, rx_cnt, cap;
   logic tx_full, tx_empty, rx_full, rx_empty;
   logic tx_busy;
   logic aw_hold, w_hold;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic do_wr, do_rd;
   logic tick;
   logic tx_done_ev, rx_done_ev, ovr_ev, tx_push, rx_pop, rx_push;
   logic [7:0] rx_byte;

   // fifo mode uses full depth, character mode a single slot
   assign cap = lctl[LCTL_FEN] ? (AW+1)'(DEPTH) : (AW+1)'(1); // R14
   assign tx_cnt = tx_wp - tx_rp;
   assign rx_cnt = rx_wp - rx_rp;
   assign tx_empty = (tx_cnt == '0); // R1
   assign tx_full = (tx_cnt >= cap); // R3
   assign rx_empty = (rx_cnt == '0); // R4
   assign rx_full = (rx_cnt >= cap); // R2

   // write channel capture, either order
   assign do_wr = aw_hold && w_hold && !BVALID;
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         BVALID <= 1'b0;
         BRESP <= RESP_OKAY;
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
      end else begin
         AWREADY <= !aw_hold && !AWREADY && AWVALID;
         WREADY <= !w_hold && !WREADY && WVALID;
         if (AWVALID && AWREADY) begin
            aw_hold <= 1'b1;
            aw_addr <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_hold <= 1'b1;
            w_data <= WDATA;
         end
         if (do_wr) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            BVALID <= 1'b1;
            unique case (aw_addr)
               ADDR_IBRD, ADDR_FBRD, ADDR_LCTL, ADDR_TXDATA, ADDR_INT_STAT,
               ADDR_INT_MASK, ADDR_FLAGS, ADDR_RXDATA: BRESP <= RESP_OKAY;
               default: BRESP <= RESP_SLVERR;
            endcase
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
         end
      end
   end

   // register writes; reserved bits dropped
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         ibrd <= '0; // R7
         fbrd <= '0; // R9
         lctl <= '0;
         div_pend <= '0;
         int_mask <= '0;
      end else if (do_wr && WSTRB != 4'h0) begin
         unique case (aw_addr)
            ADDR_IBRD: ibrd <= w_data[IBRD_W-1:0]; // R7 R16
            ADDR_FBRD: fbrd <= w_data[FBRD_W-1:0]; // R9 R16
            ADDR_LCTL: begin
               lctl <= w_data[LCTL_W-1:0]; // R13
               div_pend <= '{whole: ibrd, frac: fbrd}; // R12
            end
            ADDR_INT_MASK: int_mask <= w_data[INT_W-1:0];
            default: ;
         endcase
      end
   end
   assign tx_push = do_wr && aw_addr == ADDR_TXDATA && !tx_full;

   // read channel
   assign do_rd = ARVALID && ARREADY;
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         ARREADY <= 1'b0;
         RVALID <= 1'b0;
         RDATA <= 32'h0000_0000;
         RRESP <= RESP_OKAY;
      end else begin
         ARREADY <= !ARREADY && !RVALID && ARVALID;
         if (do_rd) begin
            RVALID <= 1'b1;
            RRESP <= RESP_OKAY;
            RDATA <= 32'h0000_0000; // R16
            unique case (ARADDR)
               ADDR_FLAGS: begin
                  RDATA[FLAG_TX_EMPTY_FLAG] <= tx_empty; // R1
                  RDATA[FLAG_RX_FULL_FLAG] <= rx_full; // R2
                  RDATA[FLAG_TX_FULL_FLAG] <= tx_full; // R3
                  RDATA[FLAG_RX_EMPTY_FLAG] <= rx_empty; // R4
                  RDATA[FLAG_BUSY] <= tx_busy; // R5
               end
               ADDR_IBRD: RDATA[IBRD_W-1:0] <= ibrd;
               ADDR_FBRD: RDATA[FBRD_W-1:0] <= fbrd;
               ADDR_LCTL: RDATA[LCTL_W-1:0] <= lctl;
               ADDR_RXDATA: RDATA[7:0] <= rx_mem[rx_rp[AW-1:0]];
               ADDR_INT_STAT: RDATA[INT_W-1:0] <= int_stat;
               ADDR_INT_MASK: RDATA[INT_W-1:0] <= int_mask;
               ADDR_TXDATA: ;
               default: RRESP <= RESP_SLVERR;
            endcase
         end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
         end
      end
   end
   assign rx_pop = do_rd && ARADDR == ADDR_RXDATA && !rx_empty;

   // divider: 16x tick at clk/(int+frac/64), accumulate in 1/64 units
   logic [IBRD_W+FBRD_W:0] acc;
   logic [IBRD_W+FBRD_W:0] step;
   always_comb begin
      if (div_act.whole == '0) begin
         step = (IBRD_W+FBRD_W+1)'(FRAC_ONE); // R8
      end else begin
         step = {1'b0, div_act.whole, div_act.frac}; // R15
      end
   end
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         acc <= '0;
         tick <= 1'b0;
      end else if (acc + (IBRD_W+FBRD_W+1)'(FRAC_ONE) >= step) begin
         acc <= acc + (IBRD_W+FBRD_W+1)'(FRAC_ONE) - step;
         tick <= 1'b1;
      end else begin
         acc <= acc + (IBRD_W+FBRD_W+1)'(FRAC_ONE);
         tick <= 1'b0;
      end
   end

   // transmitter
   ufb_tx_state_t tx_state;
   logic [11:0] tx_shift;
   logic [3:0] tx_bits, tx_sub;
   logic [3:0] nbits;
   logic rx_active;
   assign nbits = 4'(5 + lctl[LCTL_WLEN_LO +: 2]);
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         tx_state <= TX_IDLE;
         tx_shift <= '1;
         tx_bits <= 4'h0;
         tx_sub <= 4'h0;
         tx_rp <= '0;
         TXD <= 1'b1;
         tx_done_ev <= 1'b0;
      end else begin
         tx_done_ev <= 1'b0;
         unique case (tx_state)
            TX_IDLE: if (!tx_empty && tick) begin
               tx_shift <= {4'hF, tx_mem[tx_rp[AW-1:0]]} | (12'hFFF << nbits);
               tx_rp <= tx_rp + 1'b1;
               tx_bits <= 4'(1 + nbits + lctl[LCTL_PEN] + 1 + lctl[LCTL_STP2]);
               tx_sub <= 4'h0;
               TXD <= 1'b0;
               tx_state <= TX_SHIFT;
            end
            TX_SHIFT: if (tick) begin
               tx_sub <= tx_sub + 1'b1;
               if (tx_sub == 4'(OVERSAMPLE - 1)) begin
                  if (tx_bits == 4'h1) begin
                     tx_state <= TX_IDLE; // R5
                     tx_done_ev <= 1'b1;
                  end
                  tx_bits <= tx_bits - 1'b1;
                  TXD <= tx_shift[0];
                  tx_shift <= {1'b1, tx_shift[11:1]};
               end
            end
         endcase
      end
   end
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         tx_wp <= '0;
      end else if (tx_push) begin
         tx_mem[tx_wp[AW-1:0]] <= w_data[7:0];
         tx_wp <= tx_wp + 1'b1;
      end
   end
   assign tx_busy = (tx_state == TX_SHIFT) || !tx_empty; // R5 R6

   // receiver, sampled mid-bit
   logic [3:0] rx_sub, rx_bits;
   logic [7:0] rx_sh;
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         rx_active <= 1'b0;
         rx_sub <= 4'h0;
         rx_bits <= 4'h0;
         rx_sh <= 8'h00;
         rx_done_ev <= 1'b0;
      end else begin
         rx_done_ev <= 1'b0;
         if (!rx_active) begin
            if (!RXD) begin
               rx_active <= 1'b1;
               rx_sub <= 4'(OVERSAMPLE / 2);
               rx_bits <= 4'(nbits + lctl[LCTL_PEN] + 2);
            end
         end else if (tick) begin
            rx_sub <= rx_sub + 1'b1;
            if (rx_sub == 4'(OVERSAMPLE - 1)) begin
               rx_bits <= rx_bits - 1'b1;
               if (rx_bits > 4'(1 + lctl[LCTL_PEN])
                  && rx_bits <= 4'(nbits + lctl[LCTL_PEN] + 1)) begin
                  rx_sh <= {RXD, rx_sh[7:1]};
               end
               if (rx_bits == 4'h1) begin
                  rx_active <= 1'b0;
                  rx_done_ev <= 1'b1;
               end
            end
         end
      end
   end
   assign rx_byte = rx_sh >> (4'(8) - 4'(nbits));
   assign rx_push = rx_done_ev && !rx_full;
   assign ovr_ev = rx_done_ev && rx_full;
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         rx_wp <= '0;
         rx_rp <= '0;
      end else begin
         if (rx_push) begin
            rx_mem[rx_wp[AW-1:0]] <= rx_byte;
            rx_wp <= rx_wp + 1'b1;
         end
         if (rx_pop) begin
            rx_rp <= rx_rp + 1'b1;
         end
      end
   end

   // active divisor swaps only between characters
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         div_act <= '0;
      end else if (tx_state == TX_IDLE && !rx_active) begin
         div_act <= div_pend; // R10
      end
   end

   // sticky interrupt status, set beats write-one clear
   logic [INT_W-1:0] ev;
   logic [INT_W-1:0] clr;
   assign ev = {ovr_ev, rx_done_ev, tx_done_ev};
   assign clr = (do_wr && aw_addr == ADDR_INT_STAT) ? w_data[INT_W-1:0] : '0;
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         int_stat <= '0;
         IRQ <= 1'b0;
      end else begin
         int_stat <= (int_stat & ~clr) | ev;
         IRQ <= |(((int_stat & ~clr) | ev) & int_mask);
      end
   end
endmodule

//--- verilog/ufb_pkg.sv
// package for the uart flag and baud divisor block
// assumes a 32-bit axi4-lite register bus
package ufb_pkg;
   localparam logic [7:0] ADDR_FLAGS = 8'h18;
   localparam logic [7:0] ADDR_IBRD = 8'h24;
   localparam logic [7:0] ADDR_FBRD = 8'h28;
   localparam logic [7:0] ADDR_LCTL = 8'h2C;
   localparam logic [7:0] ADDR_TXDATA = 8'h00;
   localparam logic [7:0] ADDR_RXDATA = 8'h04;
   localparam logic [7:0] ADDR_INT_STAT = 8'h40;
   localparam logic [7:0] ADDR_INT_MASK = 8'h44;
   localparam int FLAG_TX_EMPTY_FLAG = 7;
   localparam int FLAG_RX_FULL_FLAG = 6;
   localparam int FLAG_TX_FULL_FLAG = 5;
   localparam int FLAG_RX_EMPTY_FLAG = 4;
   localparam int FLAG_BUSY = 3;
   localparam int IBRD_W = 16;
   localparam int FBRD_W = 6;
   localparam int LCTL_W = 8;
   localparam int LCTL_FEN = 4;
   localparam int LCTL_STP2 = 3;
   localparam int LCTL_PEN = 1;
   localparam int LCTL_WLEN_LO = 5;
   localparam int OVERSAMPLE = 16;
   localparam int FRAC_ONE = 64;
   localparam int INT_W = 3;
   localparam int INT_TXDONE = 0;
   localparam int INT_RXDONE = 1;
   localparam int INT_OVERRUN = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic [IBRD_W-1:0] whole;
      logic [FBRD_W-1:0] frac;
   } ufb_div_t;
   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} ufb_tx_state_t;
endpackage

//--- tb/ufb_peer.sv
// serial peer: sends one 8n1 frame on rxd per go pulse
// assumes bit length in ref_clk cycles, line idles high
`timescale 1ns/1ps
module ufb_peer (
   input wire logic clk,
   input wire logic go,
   input wire logic [7:0] data,
   input wire logic [31:0] bit_cyc,
   output logic rxd
);
   logic [9:0] frame;
   initial rxd = 1'b1;
   always @(posedge clk) begin
      if (go) begin
         frame = {1'b1, data, 1'b0};
         for (int i = 0; i < 10; i++) begin
            rxd <= frame[i];
            repeat (bit_cyc) @(posedge clk);
         end
      end
   end
endmodule

//--- tb/ufb_uart_chk.sv
// checker: bus answers and register read-back of ufb_uart
// assumes bound onto ufb_uart, one clock domain
`timescale 1ns/1ps
module ufb_uart_chk
   import ufb_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic [1:0] BRESP,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic [1:0] RRESP,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic RXD,
   input wire logic TXD,
   input wire logic IRQ
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   sequence s_rd(a);
      ARVALID && ARREADY && ARADDR == a;
   endsequence
   sequence s_aw;
      AWVALID && AWREADY;
   endsequence
   property p_b_stand;
      BVALID && !BREADY |=> BVALID && $stable(BRESP);
   endproperty
   a_b_stand: assert property (p_b_stand) else $error("write answer dropped early");
   property p_r_stand;
      RVALID && !RREADY |=> RVALID && $stable(RDATA);
   endproperty
   a_r_stand: assert property (p_r_stand) else $error("read answer dropped early");
   property p_b_answer;
      s_aw |-> ##[1:4] BVALID;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("no write answer");
   property p_r_answer;
      ARVALID && ARREADY |=> RVALID;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("late read answer");
   property p_flag_rsvd;
      s_rd(ADDR_FLAGS) |=> RDATA[31:8] == 24'h0 && RDATA[2:0] == 3'h0;
   endproperty
   a_flag_rsvd: assert property (p_flag_rsvd) else $error("flag spare bits set");
   property p_flag_sane;
      s_rd(ADDR_FLAGS) |=> (RDATA[FLAG_TX_EMPTY_FLAG] || RDATA[FLAG_BUSY])
         && !(RDATA[FLAG_TX_EMPTY_FLAG] && RDATA[FLAG_TX_FULL_FLAG]) && !(RDATA[FLAG_RX_EMPTY_FLAG] && RDATA[FLAG_RX_FULL_FLAG]);
   endproperty
   a_flag_sane: assert property (p_flag_sane) else $error("flag combination");
   property p_whole;
      s_rd(ADDR_IBRD) |=> RDATA[31:16] == 16'h0;
   endproperty
   a_whole: assert property (p_whole) else $error("whole divisor spare bits");
   property p_frac;
      s_rd(ADDR_FBRD) |=> RDATA[31:6] == 26'h0;
   endproperty
   a_frac: assert property (p_frac) else $error("fraction spare bits");
   property p_reset;
      disable iff (1'b0) !RESETN |=> TXD && !IRQ && !BVALID && !RVALID;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not at rest in reset");
endmodule
bind ufb_uart ufb_uart_chk i_ufb_uart_chk (.REF_CLK(REF_CLK), .RESETN(RESETN),
   .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
   .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
   .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
   .RVALID(RVALID), .RREADY(RREADY), .RXD(RXD), .TXD(TXD), .IRQ(IRQ));

//--- tb/testbench.sv
// testbench: register tasks, serial peer, flag and divisor tests
// assumes ufb_uart at 25 MHz, peer on its rx line
`timescale 1ns/1ps
module testbench
   import ufb_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic bready = 1'b0;
   logic arv = 1'b0;
   logic rready = 1'b0;
   logic go = 1'b0;
   logic [7:0] awaddr = 8'h0;
   logic [7:0] araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, rd;
   logic [1:0] bresp, rresp, rr;
   logic awready, wready, bvalid, arready, rvalid, rxd, txd, irq;
   int miscompares = 0;
   int checks_done = 0;
   int n;
   ufb_uart i_ufb_uart (.REF_CLK(clk), .RESETN(rstn), .AWADDR(awaddr), .AWVALID(awv),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wv), .WREADY(wready),
      .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arv),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .RXD(rxd), .TXD(txd), .IRQ(irq));
   ufb_peer i_ufb_peer (.clk(clk), .go(go), .data(8'hA5), .bit_cyc(32), .rxd(rxd));
   initial forever #20 clk = ~clk;
   task automatic check(input logic [31:0] seen, exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awv <= 1'b0;
         if (wready) wv <= 1'b0;
      end while (!bvalid);
      rr = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arv <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      rd_reg(a, rd, rr);
      check(rd, exp, "register");
   endtask
   task automatic bit_len(output int c);
      time t0;
      @(negedge txd);
      t0 = $time;
      @(posedge txd);
      c = int'(($time - t0) / 40);
   endtask
   task automatic wait_idle(output int c);
      time t0;
      t0 = $time;
      do rd_reg(ADDR_FLAGS, rd, rr);
      while (rd[FLAG_BUSY] !== 1'b0);
      c = int'(($time - t0) / 40);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #800000;
      miscompares++;
      complete_run();
   end
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rchk(ADDR_FLAGS, 32'h90);
      rchk(ADDR_IBRD, 32'h0);
      rchk(ADDR_FBRD, 32'h0);
      wr(ADDR_IBRD, 32'hFFFFFFFF);
      check(rr, RESP_OKAY, "write response");
      wr(ADDR_FBRD, 32'hFFFFFFFF);
      rchk(ADDR_IBRD, 32'hFFFF);
      rchk(ADDR_FBRD, 32'h3F);
      rd_reg(8'h30, rd, rr);
      check(rr, RESP_SLVERR, "unmapped response");
      wr(8'h30, 32'h0);
      check(rr, RESP_SLVERR, "unmapped write response");
      wr(ADDR_IBRD, 32'h0);
      wr(ADDR_FBRD, 32'h0);
      wr(ADDR_LCTL, 32'h6A);
      rchk(ADDR_LCTL, 32'h6A);
      wr(ADDR_LCTL, 32'h60);
      for (int i = 0; i < 3; i++) wr(ADDR_TXDATA, 32'hFF);
      rd_reg(ADDR_FLAGS, rd, rr);
      check(rd[7:3], 5'b00111, "flags tx held");
      bit_len(n);
      check(n, 16, "bit time zero divisor");
      wait_idle(n);
      wr(ADDR_IBRD, 32'h2);
      fork
         bit_len(n);
         begin
            wr(ADDR_TXDATA, 32'hFF);
            wr(ADDR_LCTL, 32'h60);
         end
      join
      check(n, 16, "bit time in flight");
      wait_idle(n);
      fork
         bit_len(n);
         wr(ADDR_TXDATA, 32'hFF);
      join
      check(n, 32, "bit time new divisor");
      wait_idle(n);
      check(n >= 288, 1, "busy through stop bit");
      check(rd, 32'h90, "flags idle");
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do rd_reg(ADDR_FLAGS, rd, rr);
      while (rd[FLAG_RX_EMPTY_FLAG] !== 1'b0);
      check(rd, 32'hC0, "flags rx held");
      check(irq, 1'b0, "irq masked");
      wr(ADDR_INT_MASK, 32'h2);
      repeat (2) @(posedge clk);
      check(irq, 1'b1, "irq raised");
      wr(ADDR_INT_STAT, 32'h2);
      repeat (2) @(posedge clk);
      check(irq, 1'b0, "irq cleared");
      rchk(ADDR_RXDATA, 32'hA5);
      rchk(ADDR_FLAGS, 32'h90);
      wr(ADDR_LCTL, 32'h70);
      for (int i = 0; i < 3; i++) wr(ADDR_TXDATA, 32'hFF);
      rd_reg(ADDR_FLAGS, rd, rr);
      check(rd[7:3], 5'b00011, "flags tx fifo");
      complete_run();
   end
endmodule
